/* core/spc_pkg.sv */
// Package for the lane PLL and clock-recovery control block.
// Holds register offsets, field positions, reset values, states and carriers.
package spc_pkg;

    localparam int unsigned ADDR_W = 12;

    localparam logic [ADDR_W-1:0] ADDR_RECOVERY_MODE = 12'h0230;
    localparam logic [ADDR_W-1:0] ADDR_EQ_BIAS = 12'h0268;
    localparam logic [ADDR_W-1:0] ADDR_SYNTH_CTRL = 12'h0280;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_STATUS = 12'h0281;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_CONFIG = 12'h0282;

    localparam logic [7:0] RST_RECOVERY_MODE = 8'h20;
    localparam logic [7:0] RST_EQ_BIAS = 8'h72;
    localparam logic [7:0] RST_SYNTH_CTRL = 8'h00;
    localparam logic [7:0] RST_LOCK_CONFIG = 8'h0C;
    localparam logic [7:0] MASK_SYNTH_CTRL = 8'h07;
    localparam logic [7:0] MASK_LOCK_CONFIG = 8'h0D;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    localparam int unsigned HALF_RATE_BIT = 5;
    localparam int unsigned OVERSAMPLE_BIT = 1;
    localparam int unsigned EQ_POWER_LSB = 6;
    localparam int unsigned RECAL_BIT = 2;
    localparam int unsigned ENABLE_BIT = 0;
    localparam int unsigned OSC_LEVEL_BIT = 0;
    localparam int unsigned LOCK_WIN_LSB = 2;

    localparam int unsigned ST_ABOVE_BIT = 5;
    localparam int unsigned ST_BELOW_BIT = 4;
    localparam int unsigned ST_PUMP_BIT = 3;
    localparam int unsigned ST_VCO_BIT = 2;
    localparam int unsigned ST_BIAS_BIT = 1;
    localparam int unsigned ST_LOCK_BIT = 0;

    typedef enum logic [4:0] {
        ST_OFF = 5'b0_0001,
        ST_BIAS = 5'b0_0010,
        ST_VCO_CAL = 5'b0_0100,
        ST_PUMP_CAL = 5'b0_1000,
        ST_RUN = 5'b1_0000
    } spc_fsm_e;

    // Analog front-end indications, all synchronous to the register clock.
    typedef struct packed {
        logic bias_ready;
        logic vco_cal_done;
        logic pump_cal_done;
        logic lock_raw;
        logic pump_above;
        logic pump_below;
    } spc_analog_s;

    // Controls driven into the analog front end.
    typedef struct packed {
        logic half_rate;
        logic oversample;
        logic [1:0] eq_power;
        logic bias_enable;
        logic vco_cal_run;
        logic pump_cal_run;
    } spc_ctrl_s;

endpackage

/* core/spc_pll_cdr_ctrl.sv */
// Control and status logic for the receive-lane PLL and clock recovery.
// Assumes a register port fed by the serial programming interface, on clk_i.
// Operation
// - Half-rate select chooses half-rate recovery above 6 Gbps; resets to one.
// - Oversample enable, reset zero, oversamples lane data for 1.44 to 2.88 Gbps.
// - Two-bit equalizer power field: 0 normal, 1 low power; resets low power.
// - Rising edge of recalibrate reruns all PLL calibrations; steady high does not.
// - Setting PLL turn-on powers bias currents, then sequences into calibration.
// - With level select zero, upper flag shows pump above upper threshold.
// - With level select zero, lower flag shows pump below lower threshold.
// - Pump calibration done flag reads one once the calibration result is valid.
// - Oscillator calibration flag reads one throughout a running VCO calibration.
// - Bias currents flag reads one once the bias currents are ready.
// - Lock flag reads one only after lock held for the window length.
// - Lock window length is a two-bit field resetting to three.
`timescale 1ns/1ps
`default_nettype none

module spc_pll_cdr_ctrl #(
    parameter int unsigned LOCK_BASE = 64, // Lock window cycles at field value zero.
    parameter int unsigned LOCK_CNT_W = 10 // Width of the lock hold counter.
) (
    input wire logic clk_i, // Register port clock, 200 MHz.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic en_i, // Clock enable; all state holds while low.
    input wire logic [spc_pkg::ADDR_W-1:0] reg_addr_i, // Register byte address.
    input wire logic reg_wr_i, // Write strobe, one cycle.
    input wire logic reg_rd_i, // Read strobe, one cycle.
    input wire logic [7:0] reg_wdata_i, // Write data.
    output logic [7:0] reg_rdata_o, // Read data, valid the cycle after reg_rd_i.
    input wire spc_pkg::spc_analog_s analog_i, // Front-end indications.
    output var spc_pkg::spc_ctrl_s ctrl_o // Front-end controls.
);

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] eq;
        logic [7:0] synth;
        logic [7:0] cfg;
        logic recal_prev;
        spc_pkg::spc_fsm_e fsm;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic [5:0] status;
        logic [7:0] rdata;
        spc_pkg::spc_ctrl_s ctrl;
    } spc_state_s;

    spc_state_s st_q;
    spc_state_s st_d;

    logic recal_edge;
    logic enable;
    logic osc_level;
    logic [1:0] lock_win;
    logic [LOCK_CNT_W-1:0] lock_target;

    assign enable = st_q.synth[spc_pkg::ENABLE_BIT];
    assign osc_level = st_q.cfg[spc_pkg::OSC_LEVEL_BIT];
    assign lock_win = st_q.cfg[spc_pkg::LOCK_WIN_LSB +: 2];
    assign lock_target = LOCK_CNT_W'((LOCK_BASE << lock_win) - 1);
    assign recal_edge = st_q.synth[spc_pkg::RECAL_BIT] & ~st_q.recal_prev;

    always_comb begin
        st_d = st_q;
        st_d.recal_prev = st_q.synth[spc_pkg::RECAL_BIT];

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                spc_pkg::ADDR_RECOVERY_MODE: st_d.mode = reg_wdata_i;
                spc_pkg::ADDR_EQ_BIAS: st_d.eq = reg_wdata_i;
                spc_pkg::ADDR_SYNTH_CTRL: st_d.synth = reg_wdata_i & spc_pkg::MASK_SYNTH_CTRL;
                spc_pkg::ADDR_LOCK_CONFIG: st_d.cfg = reg_wdata_i & spc_pkg::MASK_LOCK_CONFIG;
                default: st_d.mode = st_q.mode;
            endcase
        end

        unique case (st_q.fsm)
            spc_pkg::ST_OFF: begin
                if (enable) begin
                    st_d.fsm = spc_pkg::ST_BIAS;
                end
            end
            spc_pkg::ST_BIAS: begin
                if (analog_i.bias_ready) begin
                    st_d.fsm = spc_pkg::ST_VCO_CAL;
                end
            end
            spc_pkg::ST_VCO_CAL: begin
                if (analog_i.vco_cal_done) begin
                    st_d.fsm = spc_pkg::ST_PUMP_CAL;
                end
            end
            spc_pkg::ST_PUMP_CAL: begin
                if (analog_i.pump_cal_done) begin
                    st_d.fsm = spc_pkg::ST_RUN;
                end
            end
            spc_pkg::ST_RUN: begin
                st_d.fsm = spc_pkg::ST_RUN;
            end
        endcase
        if (recal_edge && st_q.fsm != spc_pkg::ST_OFF && st_q.fsm != spc_pkg::ST_BIAS) begin
            st_d.fsm = spc_pkg::ST_VCO_CAL;
        end
        // Turning the PLL off wins over everything and drops all progress.
        if (!enable) begin
            st_d.fsm = spc_pkg::ST_OFF;
        end

        if (st_q.fsm == spc_pkg::ST_RUN && analog_i.lock_raw) begin
            if (st_q.lock_cnt >= lock_target) begin
                st_d.status[spc_pkg::ST_LOCK_BIT] = 1'b1;
            end else begin
                st_d.lock_cnt = st_q.lock_cnt + LOCK_CNT_W'(1);
            end
        end else begin
            st_d.lock_cnt = '0;
            st_d.status[spc_pkg::ST_LOCK_BIT] = 1'b0;
        end
        if (st_d.fsm != spc_pkg::ST_RUN) begin
            st_d.lock_cnt = '0;
            st_d.status[spc_pkg::ST_LOCK_BIT] = 1'b0;
        end

        st_d.status[spc_pkg::ST_ABOVE_BIT] = ~osc_level & analog_i.pump_above;
        st_d.status[spc_pkg::ST_BELOW_BIT] = ~osc_level & analog_i.pump_below;
        st_d.status[spc_pkg::ST_PUMP_BIT] = (st_d.fsm == spc_pkg::ST_RUN);
        st_d.status[spc_pkg::ST_VCO_BIT] = (st_d.fsm == spc_pkg::ST_VCO_CAL);
        st_d.status[spc_pkg::ST_BIAS_BIT] = (st_d.fsm != spc_pkg::ST_OFF)
                                            && (st_d.fsm != spc_pkg::ST_BIAS);

        st_d.ctrl.half_rate = st_d.mode[spc_pkg::HALF_RATE_BIT];
        st_d.ctrl.oversample = st_d.mode[spc_pkg::OVERSAMPLE_BIT];
        st_d.ctrl.eq_power = st_d.eq[spc_pkg::EQ_POWER_LSB +: 2];
        st_d.ctrl.bias_enable = (st_d.fsm != spc_pkg::ST_OFF);
        st_d.ctrl.vco_cal_run = (st_d.fsm == spc_pkg::ST_VCO_CAL);
        st_d.ctrl.pump_cal_run = (st_d.fsm == spc_pkg::ST_PUMP_CAL);

        // Reads show the stored values; unmapped addresses read zero.
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                spc_pkg::ADDR_RECOVERY_MODE: st_d.rdata = st_q.mode;
                spc_pkg::ADDR_EQ_BIAS: st_d.rdata = st_q.eq;
                spc_pkg::ADDR_SYNTH_CTRL: st_d.rdata = st_q.synth;
                spc_pkg::ADDR_LOCK_STATUS: st_d.rdata = {2'b00, st_q.status};
                spc_pkg::ADDR_LOCK_CONFIG: st_d.rdata = st_q.cfg;
                default: st_d.rdata = spc_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q.mode <= spc_pkg::RST_RECOVERY_MODE;
            st_q.eq <= spc_pkg::RST_EQ_BIAS;
            st_q.synth <= spc_pkg::RST_SYNTH_CTRL;
            st_q.cfg <= spc_pkg::RST_LOCK_CONFIG;
            st_q.recal_prev <= 1'b0;
            st_q.fsm <= spc_pkg::ST_OFF;
            st_q.lock_cnt <= '0;
            st_q.status <= '0;
            st_q.rdata <= '0;
            st_q.ctrl.half_rate <= spc_pkg::RST_RECOVERY_MODE[spc_pkg::HALF_RATE_BIT];
            st_q.ctrl.oversample <= 1'b0;
            st_q.ctrl.eq_power <= spc_pkg::RST_EQ_BIAS[spc_pkg::EQ_POWER_LSB +: 2];
            st_q.ctrl.bias_enable <= 1'b0;
            st_q.ctrl.vco_cal_run <= 1'b0;
            st_q.ctrl.pump_cal_run <= 1'b0;
        end else if (en_i) begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o = st_q.rdata;
    assign ctrl_o = st_q.ctrl;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_mode_write;
        en_i && reg_wr_i && reg_addr_i == spc_pkg::ADDR_RECOVERY_MODE;
    endsequence

    sequence s_recal_rise;
        en_i && recal_edge && enable
            && (st_q.fsm == spc_pkg::ST_RUN || st_q.fsm == spc_pkg::ST_PUMP_CAL);
    endsequence

    chk_half_rate_write: assert property (s_mode_write |=>
        ctrl_o.half_rate == $past(reg_wdata_i[spc_pkg::HALF_RATE_BIT]))
        else $error("half rate select did not follow write");
    chk_oversample_write: assert property (s_mode_write |=>
        ctrl_o.oversample == $past(reg_wdata_i[spc_pkg::OVERSAMPLE_BIT]))
        else $error("oversample enable did not follow write");
    chk_eq_power_write: assert property (en_i && reg_wr_i
        && reg_addr_i == spc_pkg::ADDR_EQ_BIAS |=>
        ctrl_o.eq_power == $past(reg_wdata_i[spc_pkg::EQ_POWER_LSB +: 2]))
        else $error("equalizer power did not follow write");
    chk_recal_restart: assert property (s_recal_rise |=>
        ctrl_o.vco_cal_run && !st_q.status[spc_pkg::ST_PUMP_BIT])
        else $error("recalibrate edge did not restart calibration");
    chk_recal_level: assert property (en_i && st_q.recal_prev
        && st_q.fsm == spc_pkg::ST_RUN && enable |=> !ctrl_o.vco_cal_run)
        else $error("steady recalibrate level retriggered calibration");
    chk_enable_bias: assert property (en_i && enable
        && st_q.fsm == spc_pkg::ST_OFF |=> ctrl_o.bias_enable && !ctrl_o.vco_cal_run)
        else $error("turn-on did not start with bias currents");
    chk_upper_flag: assert property (en_i |=>
        st_q.status[spc_pkg::ST_ABOVE_BIT]
        == ($past(analog_i.pump_above) && !$past(osc_level)))
        else $error("upper pump flag wrong");
    chk_lower_flag: assert property (en_i |=>
        st_q.status[spc_pkg::ST_BELOW_BIT]
        == ($past(analog_i.pump_below) && !$past(osc_level)))
        else $error("lower pump flag wrong");
    chk_pump_valid: assert property (en_i && enable && !recal_edge
        && st_q.fsm == spc_pkg::ST_PUMP_CAL && analog_i.pump_cal_done
        |=> st_q.status[spc_pkg::ST_PUMP_BIT])
        else $error("pump calibration valid flag not set");
    chk_vco_flag: assert property (en_i && enable && st_q.status[spc_pkg::ST_VCO_BIT]
        && !analog_i.vco_cal_done |=> st_q.status[spc_pkg::ST_VCO_BIT] && ctrl_o.vco_cal_run)
        else $error("oscillator calibration flag dropped while calibration ran");
    chk_bias_flag: assert property (st_q.status[spc_pkg::ST_BIAS_BIT]
        |-> ctrl_o.bias_enable)
        else $error("bias ready flag without bias enable");
    chk_lock_hold: assert property ($rose(st_q.status[spc_pkg::ST_LOCK_BIT])
        |-> $past(analog_i.lock_raw) && $past(st_q.lock_cnt) >= $past(lock_target))
        else $error("lock flag set before window elapsed");
    chk_lock_reset: assert property ($rose(rst_n_i) |->
        lock_win == spc_pkg::RST_LOCK_CONFIG[spc_pkg::LOCK_WIN_LSB +: 2])
        else $error("lock window length reset value wrong");
    chk_status_ro: assert property (en_i && reg_wr_i
        && reg_addr_i == spc_pkg::ADDR_LOCK_STATUS |=> $stable(st_q.synth)
        && $stable(st_q.mode) && $stable(st_q.eq) && $stable(st_q.cfg))
        else $error("status write disturbed control register");

endmodule

`default_nettype wire

/* tb/spc_testbench.sv */
// Self-checking bench for the lane PLL and clock-recovery control block.
// Assumes the block alone, driven directly at its register port and analog inputs.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic [spc_pkg::ADDR_W-1:0] addr = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] seen;
    spc_pkg::spc_analog_s ana = '0;
    spc_pkg::spc_ctrl_s ctrl;
    int error_cnt = 0;
    int samples_checked = 0;

    // A short lock base keeps the window at 4 << field cycles.
    spc_pll_cdr_ctrl #(.LOCK_BASE(4), .LOCK_CNT_W(10)) spc_pll_cdr_ctrl_i (
        .clk_i(clk),
        .rst_n_i(rst_n),
        .en_i(en),
        .reg_addr_i(addr),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .analog_i(ana),
        .ctrl_o(ctrl)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [spc_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        tick(1);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [spc_pkg::ADDR_W-1:0] a, input logic [7:0] exp);
        tick(1);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        seen = rdata;
        check(seen, exp);
    endtask

    task automatic done(input string name);
        $display("test %s done, mismatches so far %0d", name, error_cnt);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        error_cnt++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check({1'b0, ctrl}, 8'h48);
        rd_chk(spc_pkg::ADDR_RECOVERY_MODE, 8'h20);
        rd_chk(spc_pkg::ADDR_EQ_BIAS, 8'h72);
        rd_chk(spc_pkg::ADDR_SYNTH_CTRL, 8'h00);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h00);
        rd_chk(spc_pkg::ADDR_LOCK_CONFIG, 8'h0C);
        done("reset");
        wr_reg(spc_pkg::ADDR_RECOVERY_MODE, 8'h02);
        tick(1);
        check({1'b0, ctrl}, 8'h28);
        rd_chk(spc_pkg::ADDR_RECOVERY_MODE, 8'h02);
        wr_reg(spc_pkg::ADDR_EQ_BIAS, 8'h32);
        tick(1);
        check({1'b0, ctrl}, 8'h20);
        wr_reg(spc_pkg::ADDR_LOCK_STATUS, 8'hFF);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h00);
        rd_chk(12'h0123, 8'h00);
        // With the enable low the write must leave no trace.
        en = 1'b0;
        wr_reg(spc_pkg::ADDR_RECOVERY_MODE, 8'hAA);
        en = 1'b1;
        rd_chk(spc_pkg::ADDR_RECOVERY_MODE, 8'h02);
        done("registers");
        wr_reg(spc_pkg::ADDR_SYNTH_CTRL, 8'h04);
        tick(3);
        check({1'b0, ctrl}, 8'h20);
        wr_reg(spc_pkg::ADDR_SYNTH_CTRL, 8'h01);
        tick(3);
        check({1'b0, ctrl}, 8'h24);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h00);
        ana.bias_ready = 1'b1;
        tick(3);
        check({1'b0, ctrl}, 8'h26);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h06);
        ana.vco_cal_done = 1'b1;
        tick(3);
        check({1'b0, ctrl}, 8'h25);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h02);
        ana.pump_cal_done = 1'b1;
        tick(3);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h0A);
        done("power-up sequence");
        wr_reg(spc_pkg::ADDR_LOCK_CONFIG, 8'h00);
        ana.lock_raw = 1'b1;
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h0A);
        tick(8);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h0B);
        ana.pump_above = 1'b1;
        ana.pump_below = 1'b1;
        tick(2);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h3B);
        wr_reg(spc_pkg::ADDR_LOCK_CONFIG, 8'h01);
        tick(2);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h0B);
        done("lock and pump flags");
        ana.vco_cal_done = 1'b0;
        ana.pump_cal_done = 1'b0;
        wr_reg(spc_pkg::ADDR_SYNTH_CTRL, 8'h05);
        tick(3);
        check({1'b0, ctrl}, 8'h26);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h06);
        ana.vco_cal_done = 1'b1;
        ana.pump_cal_done = 1'b1;
        tick(10);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h0B);
        ana.vco_cal_done = 1'b0;
        ana.pump_cal_done = 1'b0;
        wr_reg(spc_pkg::ADDR_SYNTH_CTRL, 8'h05);
        tick(3);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h0B);
        wr_reg(spc_pkg::ADDR_SYNTH_CTRL, 8'h01);
        wr_reg(spc_pkg::ADDR_SYNTH_CTRL, 8'h05);
        tick(3);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h06);
        done("recalibration");
        wr_reg(spc_pkg::ADDR_SYNTH_CTRL, 8'h00);
        tick(2);
        check({1'b0, ctrl}, 8'h20);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h00);
        done("disable");
        // A reset in mid-run must restore the registers and clear the read data at once.
        rd_chk(spc_pkg::ADDR_RECOVERY_MODE, 8'h02);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        check(rdata, 8'h00);
        check({1'b0, ctrl}, 8'h48);
        rd_chk(spc_pkg::ADDR_RECOVERY_MODE, 8'h20);
        rd_chk(spc_pkg::ADDR_LOCK_STATUS, 8'h30);
        done("mid-run reset");
        results();
    end
endmodule

`default_nettype wire
